/* File: rtl/conv_ctrl_defs.svh */
// Register offsets, field positions, reset values and timing counts of the converter control block
`ifndef CONV_CTRL_DEFS_SVH
`define CONV_CTRL_DEFS_SVH

`define OFS_CFG 12'h000
`define OFS_OFFSET 12'h004
`define OFS_GAIN 12'h008
`define OFS_DATA 12'h00c
`define OFS_FLAGS 12'h010
`define OFS_MASK 12'h014
`define OFS_DMA_CFG 12'h018
`define OFS_DMA_SIZE 12'h01c
`define OFS_DMA_CUR 12'h020
`define OFS_STATUS 12'h024

`define CFG_ENABLE_BIT 0
`define CFG_SLOW_BIT 1
`define CFG_PERIOD_LSB 2
`define CFG_NEG_LSB 8
`define CFG_POS_LSB 12

`define DMA_LOAD_BIT 0
`define DMA_WRAP_BIT 1
`define DMA_RESET_BIT 4

`define FLAG_DATA 0
`define FLAG_HALF 1
`define FLAG_FULL 2
`define FLAG_SAT 3
`define FLAG_OVF 4
`define FLAG_WIDTH 5

`define RST_OFFSET 16'h0000
`define RST_GAIN 16'h8000
`define RST_NEG_SEL 4'h9
`define RST_DMA_SIZE 16'h0001

`define CLK_HZ 200000000
`define FAST_SAMPLE_HZ 6000000
`define SLOW_SAMPLE_HZ 1000000
`define STARTUP_NS 21000
`define BASE_SAMPLE_CLOCKS 32

`endif

/* File: rtl/conv_ctrl_pkg.sv */
// Types shared by the converter control block
package conv_ctrl_pkg;
    typedef enum logic [1:0] {
        CONV_IDLE = 2'b00,
        CONV_STARTUP = 2'b01,
        CONV_RUN = 2'b10
    } conv_state_t;

    typedef logic [3:0] input_select_t;
    // One-hot analog route: bits 0-5 external inputs, 6 ground, 7 half reference, 8 reference, 9 half supply
    typedef logic [9:0] input_route_t;
endpackage

/* File: rtl/sample_tick_gen.sv */
// Fractional divider producing sample clock ticks at FAST_HZ or SLOW_HZ, chosen by slow_sel, from the system clock
`timescale 1ns/100ps
`default_nettype none
`include "conv_ctrl_defs.svh"
module sample_tick_gen #(
    parameter int CLK_HZ = `CLK_HZ,
    parameter int FAST_HZ = `FAST_SAMPLE_HZ,
    parameter int SLOW_HZ = `SLOW_SAMPLE_HZ
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow_sel,
    output logic tick
);
    typedef struct packed {
        logic [31:0] acc;
        logic tick;
    } tick_state_t;

    tick_state_t s;
    tick_state_t next_s;
    logic [31:0] sum;

    // Rate is the clk frequency times the programmed ratio over CLK_HZ, so sample timing holds only with clk at CLK_HZ
    always_comb begin
        next_s = s;
        sum = s.acc + (slow_sel ? 32'(SLOW_HZ) : 32'(FAST_HZ));
        if (sum >= 32'(CLK_HZ)) begin
            next_s.acc = sum - 32'(CLK_HZ);
            next_s.tick = 1'b1;
        end else begin
            next_s.acc = sum;
            next_s.tick = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;
endmodule
`default_nettype wire

/* File: rtl/gain_corrector.sv */
// Offset add, gain multiply with signed 16-bit clamp, and final halving
`timescale 1ns/100ps
`default_nettype none
module gain_corrector (
    input wire logic [15:0] raw,
    input wire logic [15:0] offset,
    input wire logic [15:0] gain,
    output logic [15:0] result,
    output logic saturated
);
    logic signed [16:0] sum;
    logic signed [33:0] product;
    logic signed [18:0] scaled;
    logic signed [15:0] clamped;

    always_comb begin
        sum = 17'($signed(raw)) + 17'($signed(offset));
        product = 34'(sum) * $signed({18'h00000, gain});
        scaled = 19'(product >>> 15);
        saturated = 1'b0;
        if (scaled > 19'sh07fff) begin
            clamped = 16'sh7fff;
            saturated = 1'b1;
        end else if (scaled < -19'sh08000) begin
            clamped = -16'sh8000;
            saturated = 1'b1;
        end else begin
            clamped = scaled[15:0];
        end
        result = 16'(clamped >>> 1);
    end
endmodule
`default_nettype wire

/* File: rtl/conv_ctrl.sv */
// Sigma-delta converter control: input routing, sample timing, result packing, event flags and APB registers
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "conv_ctrl_defs.svh"
module conv_ctrl
    import conv_ctrl_pkg::*;
#(
    parameter int STARTUP_CYCLES = (`STARTUP_NS * (`CLK_HZ / 1000000) + 999) / 1000,
    parameter int CLK_HZ = `CLK_HZ
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic modulator_bit,
    output logic sample_tick,
    output logic slow_sample_clock_select,
    output conv_ctrl_pkg::input_select_t positive_input_select,
    output conv_ctrl_pkg::input_select_t negative_input_select,
    output conv_ctrl_pkg::input_route_t positive_route,
    output conv_ctrl_pkg::input_route_t negative_route,
    output logic converter_enable,
    output logic dma_write_valid,
    output logic [15:0] dma_write_index,
    output logic [15:0] dma_write_data,
    output logic converter_irq
);
    import conv_ctrl_pkg::*;

    typedef struct packed {
        logic enable;
        logic slow;
        logic [2:0] period;
        input_select_t neg_sel;
        input_select_t pos_sel;
        logic [15:0] offset;
        logic [15:0] gain;
        logic [15:0] data;
        logic [4:0] flags;
        logic [4:0] mask;
        logic dma_active;
        logic dma_wrap;
        logic [15:0] dma_size;
        logic [15:0] dma_index;
        conv_state_t conv;
        logic [15:0] wait_cnt;
        logic [12:0] tick_cnt;
        logic [12:0] ones;
        logic discard;
        logic [15:0] raw;
        logic raw_valid;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic dma_valid;
        logic [15:0] dma_wr_index;
        logic [15:0] dma_wr_data;
        input_route_t pos_route;
        input_route_t neg_route;
        logic tick_out;
    } state_t;

    state_t s;
    state_t next_s;
    logic [1:0] rst_sync;
    logic rst_n;
    logic [1:0] mod_sync;
    logic tick;
    logic [15:0] corrected;
    logic saturated;

    logic access;
    logic wr_en;
    logic [4:0] flag_set;
    logic [4:0] flag_clr;
    logic [12:0] sample_clocks;
    logic [12:0] next_ones;
    logic signed [31:0] centered;
    logic signed [31:0] packed_val;
    logic [15:0] keep_mask;
    logic [15:0] half_last;
    logic cfg_write;

    // Reset released through two flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Modulator bit comes from the analog side
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mod_sync <= 2'b00;
        end else begin
            mod_sync <= {mod_sync[0], modulator_bit};
        end
    end

    sample_tick_gen #(
        .CLK_HZ(CLK_HZ),
        .FAST_HZ(`FAST_SAMPLE_HZ),
        .SLOW_HZ(`SLOW_SAMPLE_HZ)
    ) u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .slow_sel(s.slow),
        .tick(tick)
    );

    gain_corrector u_gain (
        .raw(s.raw),
        .offset(s.offset),
        .gain(s.gain),
        .result(corrected),
        .saturated(saturated)
    );

    function automatic input_route_t route(input input_select_t sel);
        input_route_t r;
        r = '0;
        if (sel <= 4'h5) begin
            r[sel] = 1'b1;
        end else if (sel >= 4'h8 && sel <= 4'hb) begin
            r[6 + (sel - 4'h8)] = 1'b1;
        end
        return r;
    endfunction

    always_comb begin
        next_s = s;
        flag_set = '0;
        flag_clr = '0;
        cfg_write = 1'b0;
        access = psel && penable;
        wr_en = access && pwrite && s.pready;
        sample_clocks = 13'(`BASE_SAMPLE_CLOCKS) << s.period;
        next_ones = s.ones + {12'h000, mod_sync[1]};
        centered = 32'(next_ones) - 32'(sample_clocks >> 1);
        packed_val = centered <<< (5'd11 - {2'b00, s.period});
        keep_mask = 16'hffff << (4'd9 - {1'b0, s.period});
        half_last = (s.dma_size >> 1) - 16'h0001;

        // APB: one wait state, answer registered
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;
        if (access && !s.pready) begin
            next_s.pready = 1'b1;
            next_s.prdata = '0;
            if (paddr == `OFS_CFG) begin
                next_s.prdata[`CFG_ENABLE_BIT] = s.enable;
                next_s.prdata[`CFG_SLOW_BIT] = s.slow;
                next_s.prdata[`CFG_PERIOD_LSB +: 3] = s.period;
                next_s.prdata[`CFG_NEG_LSB +: 4] = s.neg_sel;
                next_s.prdata[`CFG_POS_LSB +: 4] = s.pos_sel;
            end else if (paddr == `OFS_OFFSET) begin
                next_s.prdata[15:0] = s.offset;
            end else if (paddr == `OFS_GAIN) begin
                next_s.prdata[15:0] = s.gain;
            end else if (paddr == `OFS_DATA) begin
                next_s.prdata[15:0] = s.data;
            end else if (paddr == `OFS_FLAGS) begin
                next_s.prdata[4:0] = s.flags;
            end else if (paddr == `OFS_MASK) begin
                next_s.prdata[4:0] = s.mask;
            end else if (paddr == `OFS_DMA_CFG) begin
                next_s.prdata[`DMA_WRAP_BIT] = s.dma_wrap;
            end else if (paddr == `OFS_DMA_SIZE) begin
                next_s.prdata[15:0] = s.dma_size;
            end else if (paddr == `OFS_DMA_CUR) begin
                next_s.prdata[15:0] = s.dma_index;
            end else if (paddr == `OFS_STATUS) begin
                next_s.prdata[0] = s.dma_active;
                next_s.prdata[2:1] = s.conv;
            end else begin
                next_s.pslverr = 1'b1;
            end
        end

        if (wr_en) begin
            if (paddr == `OFS_CFG) begin
                next_s.enable = pwdata[`CFG_ENABLE_BIT];
                next_s.slow = pwdata[`CFG_SLOW_BIT];
                next_s.period = pwdata[`CFG_PERIOD_LSB +: 3];
                next_s.neg_sel = pwdata[`CFG_NEG_LSB +: 4];
                next_s.pos_sel = pwdata[`CFG_POS_LSB +: 4];
                cfg_write = 1'b1;
            end else if (paddr == `OFS_OFFSET) begin
                next_s.offset = pwdata[15:0];
            end else if (paddr == `OFS_GAIN) begin
                next_s.gain = pwdata[15:0];
            end else if (paddr == `OFS_FLAGS) begin
                flag_clr = pwdata[4:0];
            end else if (paddr == `OFS_MASK) begin
                next_s.mask = pwdata[4:0];
            end else if (paddr == `OFS_DMA_CFG) begin
                next_s.dma_wrap = pwdata[`DMA_WRAP_BIT];
                if (pwdata[`DMA_RESET_BIT]) begin
                    next_s.dma_active = 1'b0;
                    next_s.dma_index = '0;
                end else if (pwdata[`DMA_LOAD_BIT]) begin
                    next_s.dma_active = 1'b1;
                end
            end else if (paddr == `OFS_DMA_SIZE) begin
                next_s.dma_size = pwdata[15:0];
            end
        end

        // Conversion sequencing
        next_s.raw_valid = 1'b0;
        case (s.conv)
            CONV_IDLE: begin
                if (next_s.enable) begin
                    next_s.conv = CONV_STARTUP;
                    next_s.wait_cnt = 16'(STARTUP_CYCLES - 1);
                    next_s.discard = 1'b1;
                end
            end
            CONV_STARTUP: begin
                if (!next_s.enable) begin
                    next_s.conv = CONV_IDLE;
                end else if (s.wait_cnt == 16'h0000) begin
                    next_s.conv = CONV_RUN;
                    next_s.tick_cnt = '0;
                    next_s.ones = '0;
                end else begin
                    next_s.wait_cnt = s.wait_cnt - 16'h0001;
                end
            end
            CONV_RUN: begin
                if (!next_s.enable) begin
                    next_s.conv = CONV_IDLE;
                end else if (cfg_write) begin
                    next_s.discard = 1'b1;
                    next_s.tick_cnt = '0;
                    next_s.ones = '0;
                end else if (tick) begin
                    if (s.tick_cnt == sample_clocks - 13'h0001) begin
                        next_s.tick_cnt = '0;
                        next_s.ones = '0;
                        next_s.discard = 1'b0;
                        next_s.raw_valid = !s.discard;
                        if (packed_val > 32'sh00007fff) begin
                            next_s.raw = 16'h7fff & keep_mask;
                        end else begin
                            next_s.raw = packed_val[15:0] & keep_mask;
                        end
                    end else begin
                        next_s.tick_cnt = s.tick_cnt + 13'h0001;
                        next_s.ones = next_ones;
                    end
                end
            end
            default: begin
                next_s.conv = CONV_IDLE;
            end
        endcase

        // Corrected result lands one cycle after the raw word
        next_s.dma_valid = 1'b0;
        if (s.raw_valid) begin
            next_s.data = corrected;
            flag_set[`FLAG_DATA] = 1'b1;
            flag_set[`FLAG_SAT] = saturated;
            if (s.dma_active) begin
                next_s.dma_valid = 1'b1;
                next_s.dma_wr_index = s.dma_index;
                next_s.dma_wr_data = corrected;
                next_s.dma_index = s.dma_index + 16'h0001;
                if (s.dma_index == half_last) begin
                    flag_set[`FLAG_HALF] = 1'b1;
                end
                if (s.dma_index == s.dma_size - 16'h0001) begin
                    flag_set[`FLAG_FULL] = 1'b1;
                    next_s.dma_index = '0;
                    next_s.dma_active = s.dma_wrap;
                end
            end else begin
                flag_set[`FLAG_OVF] = 1'b1;
            end
        end

        // Set wins over a clear in the same cycle
        next_s.flags = (s.flags & ~flag_clr) | flag_set;
        next_s.irq = |(next_s.flags & s.mask);
        next_s.pos_route = route(next_s.pos_sel);
        next_s.neg_route = route(next_s.neg_sel);
        next_s.tick_out = tick && (s.conv != CONV_IDLE);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.neg_sel <= `RST_NEG_SEL;
            s.neg_route <= 10'h080;
            s.pos_route <= 10'h001;
            s.offset <= `RST_OFFSET;
            s.gain <= `RST_GAIN;
            s.dma_size <= `RST_DMA_SIZE;
            s.conv <= CONV_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign sample_tick = s.tick_out;
    assign slow_sample_clock_select = s.slow;
    assign positive_input_select = s.pos_sel;
    assign negative_input_select = s.neg_sel;
    assign positive_route = s.pos_route;
    assign negative_route = s.neg_route;
    assign converter_enable = s.enable;
    assign dma_write_valid = s.dma_valid;
    assign dma_write_index = s.dma_wr_index;
    assign dma_write_data = s.dma_wr_data;
    assign converter_irq = s.irq;
endmodule
`default_nettype wire

/* File: dv/conv_ctrl_assertions.sv */
// Port-level assertions for the converter control block
`timescale 1ns/100ps
`default_nettype none
`include "conv_ctrl_defs.svh"
module conv_ctrl_assertions
    import conv_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sample_tick,
    input wire logic slow_sample_clock_select,
    input wire conv_ctrl_pkg::input_select_t positive_input_select,
    input wire conv_ctrl_pkg::input_select_t negative_input_select,
    input wire conv_ctrl_pkg::input_route_t positive_route,
    input wire conv_ctrl_pkg::input_route_t negative_route,
    input wire logic converter_enable,
    input wire logic dma_write_valid
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    function automatic input_route_t route_ref(input input_select_t s);
        if (s < 4'h6) return 10'h001 << s;
        if (s >= 4'h8 && s <= 4'hb) return 10'h001 << (s - 4'h2);
        return 10'h000;
    endfunction

    // Cycles since the last tick; gap_ok only once a full period at one rate was seen
    logic [8:0] gap;
    logic gap_ok;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gap <= 9'h000;
            gap_ok <= 1'b0;
        end else if (sample_tick) begin
            gap <= 9'h001;
            gap_ok <= converter_enable;
        end else begin
            gap <= (gap == 9'h1ff) ? gap : gap + 9'h001;
            if (!converter_enable || $changed(slow_sample_clock_select)) begin
                gap_ok <= 1'b0;
            end
        end
    end

    sequence s_wait;
        psel && penable && !pready;
    endsequence
    property p_route_pos;
        $stable(positive_input_select) |-> positive_route == route_ref(positive_input_select);
    endproperty
    property p_route_neg;
        $stable(negative_input_select) |-> negative_route == route_ref(negative_input_select);
    endproperty
    property p_apb_answer;
        s_wait |=> pready;
    endproperty
    property p_ready_cause;
        pready |-> psel && penable && $past(penable);
    endproperty
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    property p_dma_pulse;
        dma_write_valid |=> (!dma_write_valid)[*8];
    endproperty
    property p_tick_idle;
        !converter_enable && !$past(converter_enable) |-> !sample_tick;
    endproperty
    property p_tick_gap;
        sample_tick && gap_ok |-> (slow_sample_clock_select ? gap == 9'h0c8 : (gap == 9'h021 || gap == 9'h022));
    endproperty
    property p_cfg_by_write;
        $changed(converter_enable) || $changed(slow_sample_clock_select) |->
            $past(psel && penable && pready && pwrite && paddr == `OFS_CFG);
    endproperty

    a_route_pos: assert property (p_route_pos) else $error("positive route does not match selector");
    a_route_neg: assert property (p_route_neg) else $error("negative route does not match selector");
    a_apb_answer: assert property (p_apb_answer) else $error("no ready one cycle after access");
    a_ready_cause: assert property (p_ready_cause) else $error("ready without access phase");
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
    a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
    a_dma_pulse: assert property (p_dma_pulse) else $error("dma writes too close");
    a_tick_idle: assert property (p_tick_idle) else $error("tick while disabled");
    a_tick_gap: assert property (p_tick_gap) else $error("sample tick spacing wrong");
    a_cfg_by_write: assert property (p_cfg_by_write) else $error("config output changed without write");
endmodule
`default_nettype wire

/* File: dv/mod_source.sv */
// Behavioural modulator: a constant bit density into the converter
`timescale 1ns/100ps
`default_nettype none
module mod_source (
    input wire logic clk,
    input wire logic density_high,
    output logic bit_out
);
    initial bit_out = 1'b0;
    always @(posedge clk) begin
        bit_out <= density_high;
    end
endmodule
`default_nettype wire

/* File: dv/conv_ctrl_tb.sv */
// Self-checking testbench for the converter control block
`timescale 1ns/100ps
`default_nettype none
`include "conv_ctrl_defs.svh"
module conv_ctrl_tb;
    import conv_ctrl_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, modulator_bit, sample_tick, slow_sample_clock_select, converter_enable;
    logic dma_write_valid, converter_irq;
    logic ones = 1'b1;
    input_select_t positive_input_select, negative_input_select;
    input_route_t positive_route, negative_route;
    logic [15:0] dma_write_index, dma_write_data;
    int error_cnt = 0;
    int n_tests = 0;
    int ticks = 0;
    logic [15:0] idx_q[$], data_q[$];
    int gap_q[$];

    always #2.5 clk = ~clk;

    conv_ctrl #(.STARTUP_CYCLES(4)) dut_u (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .modulator_bit, .sample_tick, .slow_sample_clock_select, .positive_input_select,
        .negative_input_select, .positive_route, .negative_route, .converter_enable, .dma_write_valid,
        .dma_write_index, .dma_write_data, .converter_irq);
    mod_source model_u (.clk, .density_high(ones), .bit_out(modulator_bit));

    // Records every buffer write and the ticks counted since the previous one
    always @(posedge clk) begin
        if (sample_tick === 1'b1) ticks++;
        if (dma_write_valid === 1'b1) begin
            idx_q.push_back(dma_write_index);
            data_q.push_back(dma_write_data);
            gap_q.push_back(ticks);
            ticks = 0;
        end
    end

    task automatic complete_run();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        if (n == 50) chk(32'h0, 32'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        rd(a, q);
        chk(q, exp);
    endtask

    task automatic wait_flag(input int b);
        logic [31:0] q;
        int n;
        n = 0;
        q = 32'h0;
        while (q[b] !== 1'b1 && n < 8000) begin
            rd(`OFS_FLAGS, q);
            n++;
        end
        chk({31'h0, q[b]}, 32'h1);
    endtask

    function automatic logic [31:0] route_exp(input int c);
        if (c < 6) return 32'h1 << c;
        if (c >= 8 && c <= 11) return 32'h1 << (c - 2);
        return 32'h0;
    endfunction

    // Ones give a clamped full scale with the unused low bits cleared; zeros give the negative limit
    function automatic logic [31:0] exp_data(input logic hi, input int p);
        logic [15:0] raw;
        raw = hi ? (16'h7fff & ~((16'h0001 << (9 - p)) - 16'h0001)) : 16'h8000;
        return {16'h0000, raw[15], raw[15:1]};
    endfunction

    task automatic conv(input logic slow, input logic [2:0] p, input logic hi, input logic [31:0] exp,
                        input logic [31:0] flg);
        logic [31:0] q;
        wr(`OFS_CFG, 32'h900);
        ones <= hi;
        wr(`OFS_CFG, 32'h900 | {27'h0, p, slow, 1'b1});
        chk({31'h0, slow_sample_clock_select}, {31'h0, slow});
        chk({31'h0, converter_enable}, 32'h1);
        wr(`OFS_FLAGS, 32'h1f);
        wait_flag(0);
        rd(`OFS_DATA, q);
        chk({16'h0, q[15:0]}, exp);
        rd_chk(`OFS_FLAGS, flg);
    endtask

    initial begin
        logic [31:0] q;
        logic e;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(`OFS_CFG, 32'h900);
        rd_chk(`OFS_GAIN, 32'h8000);
        rd_chk(`OFS_FLAGS, 32'h0);
        rd_chk(`OFS_MASK, 32'h0);
        rd_chk(`OFS_DMA_SIZE, 32'h1);
        apb(1'b0, 12'h0f0, 32'h0, q, e);
        chk({q[30:0], e}, 32'h1);
        for (int c = 0; c < 16; c++) begin
            wr(`OFS_CFG, (c << 12) | ((15 - c) << 8));
            repeat (2) @(posedge clk);
            chk({22'h0, positive_route}, route_exp(c));
            chk({22'h0, negative_route}, route_exp(15 - c));
            chk({28'h0, positive_input_select}, c);
            chk({28'h0, negative_input_select}, 15 - c);
        end
        for (int p = 0; p < 3; p++) begin
            conv(1'b0, p[2:0], 1'b1, exp_data(1'b1, p), 32'h11);
        end
        conv(1'b0, 3'h0, 1'b0, exp_data(1'b0, 0), 32'h11);
        conv(1'b1, 3'h0, 1'b1, exp_data(1'b1, 0), 32'h11);
        wr(`OFS_GAIN, 32'hffff);
        conv(1'b0, 3'h0, 1'b1, 32'h3fff, 32'h19);
        wr(`OFS_CFG, 32'h900);
        wr(`OFS_MASK, 32'h0);
        repeat (2) @(posedge clk);
        chk({31'h0, converter_irq}, 32'h0);
        wr(`OFS_MASK, 32'h08);
        repeat (2) @(posedge clk);
        chk({31'h0, converter_irq}, 32'h1);
        wr(`OFS_FLAGS, 32'h00);
        rd_chk(`OFS_FLAGS, 32'h19);
        wr(`OFS_FLAGS, 32'h08);
        rd_chk(`OFS_FLAGS, 32'h11);
        chk({31'h0, converter_irq}, 32'h0);
        wr(`OFS_MASK, 32'h10);
        repeat (2) @(posedge clk);
        chk({31'h0, converter_irq}, 32'h1);
        wr(`OFS_GAIN, 32'h8000);
        wr(`OFS_DMA_CFG, 32'h10);
        wr(`OFS_DMA_SIZE, 32'h4);
        wr(`OFS_FLAGS, 32'h1f);
        wr(`OFS_DMA_CFG, 32'h01);
        wr(`OFS_CFG, 32'h901);
        wait_flag(4);
        wr(`OFS_CFG, 32'h900);
        chk(idx_q.size(), 32'h4);
        for (int i = 0; i < idx_q.size(); i++) begin
            chk({16'h0, idx_q[i]}, i);
            chk({16'h0, data_q[i]}, exp_data(1'b1, 0));
            if (i > 0) chk(gap_q[i], 32'h20);
        end
        rd_chk(`OFS_FLAGS, 32'h17);
        // Auto wrap keeps the buffer running past the end, so no overflow follows
        wr(`OFS_DMA_CFG, 32'h10);
        wr(`OFS_DMA_CFG, 32'h03);
        wr(`OFS_FLAGS, 32'h1f);
        wr(`OFS_CFG, 32'h901);
        wait_flag(2);
        rd_chk(`OFS_DMA_CFG, 32'h2);
        rd_chk(`OFS_STATUS, 32'h5);
        rd_chk(`OFS_FLAGS, 32'h07);
        wr(`OFS_CFG, 32'h900);
        complete_run();
    end

    initial begin
        #400000;
        error_cnt++;
        complete_run();
    end
endmodule

bind conv_ctrl conv_ctrl_assertions chk_u (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
    .sample_tick, .slow_sample_clock_select, .positive_input_select, .negative_input_select, .positive_route,
    .negative_route, .converter_enable, .dma_write_valid);
`default_nettype wire
